// >>> verilog/ecwm_pkg.sv
// Constants for the EEPROM autoload word mapper.
// Assumes word addresses are byte addresses of 16-bit EEPROM words.
package ecwm_pkg;
	localparam int NPORT = 3;
	// EEPROM word addresses
	localparam logic [7:0] EE_PM_P1 = 8'h82;
	localparam logic [7:0] EE_PM_P2 = 8'h84;
	localparam logic [7:0] EE_ACK_P0 = 8'h88;
	localparam logic [7:0] EE_ACK_P1 = 8'h8A;
	localparam logic [7:0] EE_ACK_P2 = 8'h8C;
	localparam logic [7:0] EE_SLO_P1 = 8'h92;
	localparam logic [7:0] EE_SLO_P2 = 8'h94;
	localparam logic [7:0] EE_SHI_P1 = 8'h9A;
	localparam logic [7:0] EE_SHI_P2 = 8'h9C;
	localparam logic [7:0] EE_VC_P0 = 8'hA0;
	localparam logic [7:0] EE_VC_P1 = 8'hA2;
	localparam logic [7:0] EE_VC_P2 = 8'hA4;
	localparam logic [4:0] EE_IDX_BASE = 5'h01;
	// Word defaults
	localparam logic [15:0] PM_DEF = 16'h33A1;
	localparam logic [15:0] ACK_DEF = 16'h0000;
	localparam logic [15:0] SLO_DEF = 16'h0000;
	localparam logic [15:0] SHI_P1_DEF = 16'h0008;
	localparam logic [15:0] SHI_P2_DEF = 16'h0010;
	localparam logic [15:0] VC_DEF = 16'h0000;
	// Word kinds
	localparam logic [2:0] K_NONE = 3'h0;
	localparam logic [2:0] K_PM = 3'h1;
	localparam logic [2:0] K_ACK = 3'h2;
	localparam logic [2:0] K_SLO = 3'h3;
	localparam logic [2:0] K_SHI = 3'h4;
	localparam logic [2:0] K_VC = 3'h5;
	// Configuration offsets
	localparam logic [9:0] CFG_070 = 10'h070;
	localparam logic [9:0] CFG_074 = 10'h074;
	localparam logic [9:0] CFG_088 = 10'h088;
	localparam logic [9:0] CFG_0D4 = 10'h0D4;
	localparam logic [9:0] CFG_15C = 10'h15C;
	localparam logic [9:0] CFG_160 = 10'h160;
	localparam logic [9:0] CFG_STAT = 10'h3FC;
	// Field positions
	localparam int PM_LO = 8;
	localparam int VGA_BIT = 31;
	localparam int TUNE_LO = 24;
	localparam int ACK_LO = 16;
	localparam int VCTS_LO = 16;
	localparam int SEEN_LO = 8;
	typedef enum logic [1:0] {
		ST_LOAD = 2'h1,
		ST_READY = 2'h2
	} ecwm_state_t;
endpackage

// >>> verilog/ecwm_top.sv
// Maps EEPROM autoload words 82h..A4h onto per-port config fields.
// Assumes an autoload engine presents each word with a valid strobe
// and flags the end of autoload; software sits on a plain reg port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Word 82h puts bits 6:0 into port 1 register 74h bits 14:8, default 33A1h.
// - Those bits mean D3-to-L1, L1 delay select, L0s enable, Rx polarity off.
// - Bit 7 of the port 1 word drives port 1 VGA decode, 70h bit 31.
// - Bits 15:8 of the port 1 word go to port 1 88h bits 31:24.
// - Word 84h does the same for port 2, default 33A1h.
// - Words 88h, 8Ah, 8Ch give the ack latency timer of ports 0..2.
// - Words 92h, 94h give the low slot capability word of ports 1, 2.
// - Words 9Ah, 9Ch give the high slot word, defaults 0008h, 0010h.
// - Words A0h..A4h bits 6:0 give VC1 max time slot, 15Ch bits 22:16.
// - Bits 15:8 of those words give the TC-to-VC1 map, 160h bits 7:0.
module ecwm_top
	import ecwm_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Autoload word stream
	input wire logic WORD_VALID_I,
	input wire logic [7:0] WORD_ADDR_I,
	input wire logic [15:0] WORD_DATA_I,
	input wire logic LOAD_DONE_I,
	// Register port
	input wire logic [11:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	// Ready flag and mapped fields, port n in slice n
	output logic CFG_READY_O,
	output logic [20:0] PM_CTRL_O,
	output logic [2:0] VGA_EN_O,
	output logic [23:0] PHY_VENDOR_TUNING_O,
	output logic [44:0] ACK_LAT_O,
	output logic [95:0] SLOT_CAP_O,
	output logic [20:0] VC1_SLOT_O,
	output logic [23:0] TC_MAP_O
);

	////////////////////////////////////////////////////////////////////
	// Decode of an EEPROM word address into kind and port
	function automatic logic [4:0] ee_kind(input logic [7:0] a);
		if (a == EE_PM_P1) begin
			return {K_PM, 2'h1};
		end else if (a == EE_PM_P2) begin
			return {K_PM, 2'h2};
		end else if (a == EE_ACK_P0) begin
			return {K_ACK, 2'h0};
		end else if (a == EE_ACK_P1) begin
			return {K_ACK, 2'h1};
		end else if (a == EE_ACK_P2) begin
			return {K_ACK, 2'h2};
		end else if (a == EE_SLO_P1) begin
			return {K_SLO, 2'h1};
		end else if (a == EE_SLO_P2) begin
			return {K_SLO, 2'h2};
		end else if (a == EE_SHI_P1) begin
			return {K_SHI, 2'h1};
		end else if (a == EE_SHI_P2) begin
			return {K_SHI, 2'h2};
		end else if (a == EE_VC_P0) begin
			return {K_VC, 2'h0};
		end else if (a == EE_VC_P1) begin
			return {K_VC, 2'h1};
		end else if (a == EE_VC_P2) begin
			return {K_VC, 2'h2};
		end
		return {K_NONE, 2'h0};
	endfunction

	////////////////////////////////////////////////////////////////////
	// State
	ecwm_state_t st_q, st_d;
	logic [17:0] seen_q, seen_d;
	logic [6:0] pm_q [NPORT];
	logic [6:0] pm_d [NPORT];
	logic vga_q [NPORT];
	logic vga_d [NPORT];
	logic [7:0] tune_q [NPORT];
	logic [7:0] tune_d [NPORT];
	logic [14:0] ack_q [NPORT];
	logic [14:0] ack_d [NPORT];
	logic [31:0] slot_q [NPORT];
	logic [31:0] slot_d [NPORT];
	logic [6:0] vcts_q [NPORT];
	logic [6:0] vcts_d [NPORT];
	logic [7:0] tc_q [NPORT];
	logic [7:0] tc_d [NPORT];
	logic [31:0] rd_q, rd_d;

	// Word decode shared by load logic and checks
	logic [4:0] wk;
	logic [2:0] w_kind;
	logic [1:0] w_port;
	logic [4:0] w_idx;
	logic w_take;
	logic [1:0] r_port;
	logic [9:0] r_off;
	assign wk = ee_kind(WORD_ADDR_I);
	assign w_kind = wk[4:2];
	assign w_port = wk[1:0];
	assign w_idx = WORD_ADDR_I[5:1] - EE_IDX_BASE;
	// A repeated word is dropped so late reads cannot undo a load
	assign w_take = (st_q == ST_LOAD) && WORD_VALID_I &&
		(w_kind != K_NONE) && !seen_q[w_idx];
	assign r_port = ADDR_I[11:10];
	assign r_off = ADDR_I[9:0];

	////////////////////////////////////////////////////////////////////
	// Next-state: autoload, then software writes
	always_comb begin
		st_d = st_q;
		seen_d = seen_q;
		pm_d = pm_q;
		vga_d = vga_q;
		tune_d = tune_q;
		ack_d = ack_q;
		slot_d = slot_q;
		vcts_d = vcts_q;
		tc_d = tc_q;
		case (st_q)
			ST_LOAD: begin
				// Config writes stay shut until LOAD_DONE_I flags the end of autoload
				if (LOAD_DONE_I) begin
					st_d = ST_READY;
				end
				if (w_take) begin
					seen_d[w_idx] = 1'b1;
					if (w_kind == K_PM) begin
						pm_d[w_port] = WORD_DATA_I[6:0];
						vga_d[w_port] = WORD_DATA_I[7];
						tune_d[w_port] = WORD_DATA_I[15:8];
					end else if (w_kind == K_ACK) begin
						ack_d[w_port] = WORD_DATA_I[14:0];
					end else if (w_kind == K_SLO) begin
						slot_d[w_port][15:0] = WORD_DATA_I;
					end else if (w_kind == K_SHI) begin
						slot_d[w_port][31:16] = WORD_DATA_I;
					end else begin
						vcts_d[w_port] = WORD_DATA_I[6:0];
						tc_d[w_port] = WORD_DATA_I[15:8];
					end
				end
			end
			ST_READY: begin
				// Only fields this block holds are writable
				if (WR_I && r_port < 2'h3) begin
					if (r_off == CFG_070) begin
						ack_d[r_port] = WDATA_I[30:16];
						if (r_port != 2'h0) begin
							vga_d[r_port] = WDATA_I[VGA_BIT];
						end
					end else if (r_off == CFG_074 && r_port != 2'h0) begin
						pm_d[r_port] = WDATA_I[14:8];
					end else if (r_off == CFG_088 && r_port != 2'h0) begin
						tune_d[r_port] = WDATA_I[31:24];
					end else if (r_off == CFG_0D4 && r_port != 2'h0) begin
						slot_d[r_port] = WDATA_I;
					end else if (r_off == CFG_15C) begin
						vcts_d[r_port] = WDATA_I[22:16];
					end else if (r_off == CFG_160) begin
						tc_d[r_port] = WDATA_I[7:0];
					end
				end
			end
			default: begin
				st_d = ST_LOAD;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Read data: valid only in the cycle after the strobe
	always_comb begin
		rd_d = 32'h0000_0000;
		if (RD_I && r_port < 2'h3) begin
			if (r_off == CFG_070) begin
				rd_d[VGA_BIT] = vga_q[r_port];
				rd_d[ACK_LO +: 15] = ack_q[r_port];
			end else if (r_off == CFG_074) begin
				rd_d[PM_LO +: 7] = pm_q[r_port];
			end else if (r_off == CFG_088) begin
				rd_d[TUNE_LO +: 8] = tune_q[r_port];
			end else if (r_off == CFG_0D4) begin
				rd_d = slot_q[r_port];
			end else if (r_off == CFG_15C) begin
				rd_d[VCTS_LO +: 7] = vcts_q[r_port];
			end else if (r_off == CFG_160) begin
				rd_d[7:0] = tc_q[r_port];
			end else if (r_off == CFG_STAT && r_port == 2'h0) begin
				rd_d[0] = (st_q == ST_READY);
				rd_d[SEEN_LO +: 18] = seen_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers; unheld port 0 fields reset to zero
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st_q <= ST_LOAD;
			seen_q <= '0;
			rd_q <= 32'h0000_0000;
			for (int i = 0; i < NPORT; i++) begin
				pm_q[i] <= (i == 0) ? 7'h00 : PM_DEF[6:0];
				vga_q[i] <= (i == 0) ? 1'b0 : PM_DEF[7];
				tune_q[i] <= (i == 0) ? 8'h00 : PM_DEF[15:8];
				ack_q[i] <= ACK_DEF[14:0];
				slot_q[i] <= (i == 1) ? {SHI_P1_DEF, SLO_DEF} :
					(i == 2) ? {SHI_P2_DEF, SLO_DEF} : 32'h0000_0000;
				vcts_q[i] <= VC_DEF[6:0];
				tc_q[i] <= VC_DEF[15:8];
			end
		end else begin
			st_q <= st_d;
			seen_q <= seen_d;
			rd_q <= rd_d;
			pm_q <= pm_d;
			vga_q <= vga_d;
			tune_q <= tune_d;
			ack_q <= ack_d;
			slot_q <= slot_d;
			vcts_q <= vcts_d;
			tc_q <= tc_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops, CFG_READY_O decoded from st_q
	assign RDATA_O = rd_q;
	assign CFG_READY_O = (st_q == ST_READY);
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			PM_CTRL_O[i*7 +: 7] = pm_q[i];
			VGA_EN_O[i] = vga_q[i];
			PHY_VENDOR_TUNING_O[i*8 +: 8] = tune_q[i];
			ACK_LAT_O[i*15 +: 15] = ack_q[i];
			SLOT_CAP_O[i*32 +: 32] = slot_q[i];
			VC1_SLOT_O[i*7 +: 7] = vcts_q[i];
			TC_MAP_O[i*8 +: 8] = tc_q[i];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_take(logic [7:0] a);
		st_q == ST_LOAD && WORD_VALID_I && WORD_ADDR_I == a &&
			!seen_q[a[5:1] - EE_IDX_BASE];
	endsequence

	AST_PM1_FIELDS: assert property (
		s_take(EE_PM_P1) |=> PM_CTRL_O[13:7] == $past(WORD_DATA_I[6:0]))
		else $error("port 1 power field not loaded");
	AST_PM1_L0S: assert property (
		s_take(EE_PM_P1) |=> PM_CTRL_O[12:11] == $past(WORD_DATA_I[5:4]))
		else $error("port 1 L0s enable lost");
	AST_VGA1: assert property (
		s_take(EE_PM_P1) |=> VGA_EN_O[1] == $past(WORD_DATA_I[7]))
		else $error("port 1 VGA decode not loaded");
	AST_TUNE1: assert property (
		s_take(EE_PM_P1) |=>
		PHY_VENDOR_TUNING_O[15:8] == $past(WORD_DATA_I[15:8]))
		else $error("port 1 tuning byte not loaded");
	AST_PM2: assert property (
		s_take(EE_PM_P2) |=> {PHY_VENDOR_TUNING_O[23:16], VGA_EN_O[2],
		PM_CTRL_O[20:14]} == $past(WORD_DATA_I))
		else $error("port 2 power word not loaded");
	AST_ACK0: assert property (
		s_take(EE_ACK_P0) |=> ACK_LAT_O[14:0] == $past(WORD_DATA_I[14:0]))
		else $error("port 0 ack latency not loaded");
	AST_SLOT_LO1: assert property (
		s_take(EE_SLO_P1) |=> SLOT_CAP_O[47:32] == $past(WORD_DATA_I))
		else $error("port 1 low slot word not loaded");
	AST_SLOT_HI2: assert property (
		s_take(EE_SHI_P2) |=> SLOT_CAP_O[95:80] == $past(WORD_DATA_I))
		else $error("port 2 high slot word not loaded");
	AST_VC1: assert property (
		s_take(EE_VC_P1) |=> VC1_SLOT_O[13:7] == $past(WORD_DATA_I[6:0]))
		else $error("port 1 VC1 time slot not loaded");
	AST_TC2: assert property (
		s_take(EE_VC_P2) |=> TC_MAP_O[23:16] == $past(WORD_DATA_I[15:8]))
		else $error("port 2 TC map not loaded");
	AST_ONCE: assert property (
		st_q == ST_LOAD && WORD_VALID_I && !w_take && !LOAD_DONE_I |=>
		$stable(PM_CTRL_O) && $stable(SLOT_CAP_O) && $stable(TC_MAP_O))
		else $error("repeated or unmapped word changed a field");
	AST_READY: assert property (
		st_q == ST_LOAD && LOAD_DONE_I |=> CFG_READY_O [*2])
		else $error("ready not raised after autoload");

endmodule

`default_nettype wire

// >>> testbench/ecwm_ee_model.sv
// Serial configuration EEPROM seen as a stream of autoload words.
// Assumes the bench fills mem before raising start_i.
`timescale 1ns/100ps
`default_nettype none

module ecwm_ee_model (
	// Clock, reset and trigger
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	// Word stream
	output logic valid_o,
	output logic [7:0] addr_o,
	output logic [15:0] data_o,
	output logic done_o
);
	logic [15:0] mem [0:255];

	////////////////////////////////////////////////////////////////////////
	// Walks 82h..A4h with gaps, then repeats 82h with done beside it;
	// one process owns every output so none has two drivers
	initial begin
		valid_o = 1'b0;
		addr_o = 8'h00;
		data_o = 16'h5A5A;
		done_o = 1'b0;
		// Idle until the bench has left reset and asked for the load
		wait (rst_n_i === 1'b1 && start_i === 1'b1);
		for (int a = 'h82; a <= 'hA6; a += 2) begin
			@(posedge clk_i);
			valid_o <= 1'b1;
			addr_o <= (a == 'hA6) ? 8'h82 : 8'(a);
			data_o <= (a == 'hA6) ? ~mem['h82] : mem[a];
			done_o <= (a == 'hA6);
			@(posedge clk_i);
			valid_o <= 1'b0;
			done_o <= 1'b0;
			// Idle data toggles so a stale word never looks valid
			data_o <= ~data_o;
			if (a[2]) begin
				@(posedge clk_i);
			end
		end
	end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the autoload word mapper.
// Assumes the EEPROM model and the package are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import ecwm_pkg::*;
	logic clk, rst_n, start, wv, done, wr, rd, ready;
	logic [7:0] wa;
	logic [15:0] wd;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, d1, d2;
	logic [20:0] pm, vc, e_pm, e_vc;
	logic [2:0] vga, e_vga;
	logic [23:0] tune, tc, e_tune, e_tc;
	logic [44:0] ack, e_ack;
	logic [95:0] slot, e_slot;
	logic [15:0] img [0:255];
	int err_total = 0;
	int num_checks = 0;

	ecwm_ee_model ee_u (.clk_i(clk), .rst_n_i(rst_n), .start_i(start),
		.valid_o(wv), .addr_o(wa), .data_o(wd), .done_o(done));

	ecwm_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .WORD_VALID_I(wv),
		.WORD_ADDR_I(wa), .WORD_DATA_I(wd), .LOAD_DONE_I(done),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .CFG_READY_O(ready), .PM_CTRL_O(pm),
		.VGA_EN_O(vga), .PHY_VENDOR_TUNING_O(tune), .ACK_LAT_O(ack),
		.SLOT_CAP_O(slot), .VC1_SLOT_O(vc), .TC_MAP_O(tc));

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; the load needs well under 100 cycles
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#(3000 * 100);
		err_total++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////
	// Compare, bus and closing tasks
	task automatic chk(input string nm, input logic [95:0] e,
		input logic [95:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic fields();
		chk("pm", 96'(e_pm), 96'(pm));
		chk("vga", 96'(e_vga), 96'(vga));
		chk("tune", 96'(e_tune), 96'(tune));
		chk("ack", 96'(e_ack), 96'(ack));
		chk("slot", e_slot, slot);
		chk("vc1", 96'(e_vc), 96'(vc));
		chk("tc", 96'(e_tc), 96'(tc));
	endtask

	// Reset values of every field; port 0 has no power, tuning or slot field of its own
	task automatic set_defaults();
		e_pm = {7'h21, 7'h21, 7'h00};
		e_vga = 3'b110;
		e_tune = {8'h33, 8'h33, 8'h00};
		e_ack = 45'h0;
		e_slot = {32'h0010_0000, 32'h0008_0000, 32'h0000_0000};
		e_vc = 21'h0;
		e_tc = 24'h0;
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(nm, 96'(e), 96'(rdata));
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h50c39a54));
		{rst_n, start, wr, rd} = 4'h0;
		addr = 12'h000;
		wdata = 32'h0000_0000;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Write while loading must be refused
		wr_reg({2'h1, CFG_160}, 32'h0000_00FF);
		set_defaults();
		fields();
		$display("test defaults done");
		for (int a = 0; a < 256; a++) begin
			img[a] = 16'($urandom);
		end
		ee_u.mem = img;
		start <= 1'b1;
		for (int i = 0; i < 200 && ready !== 1'b1; i++) begin
			@(posedge clk);
		end
		#1 chk("ready", 96'(1'b1), 96'(ready));
		e_pm = {img['h84][6:0], img['h82][6:0], 7'h00};
		e_vga = {img['h84][7], img['h82][7], 1'b0};
		e_tune = {img['h84][15:8], img['h82][15:8], 8'h00};
		e_ack = {img['h8C][14:0], img['h8A][14:0], img['h88][14:0]};
		e_slot = {img['h9C], img['h94], img['h9A], img['h92], 32'h0};
		e_vc = {img['hA4][6:0], img['hA2][6:0], img['hA0][6:0]};
		e_tc = {img['hA4][15:8], img['hA2][15:8], img['hA0][15:8]};
		fields();
		$display("test autoload done");
		d1 = $urandom;
		d2 = $urandom;
		wr_reg({2'h2, CFG_160}, d1);
		wr_reg({2'h1, CFG_070}, d2);
		e_tc[23:16] = d1[7:0];
		e_ack[29:15] = d2[30:16];
		e_vga[1] = d2[31];
		fields();
		rd_reg("slot1", {2'h1, CFG_0D4}, {img['h9A], img['h92]});
		rd_reg("pm2", {2'h2, CFG_074}, {17'h0, img['h84][6:0], 8'h0});
		rd_reg("tune1", {2'h1, CFG_088}, {img['h82][15:8], 24'h0});
		rd_reg("ctl1", {2'h1, CFG_070}, {d2[31:16], 16'h0});
		rd_reg("vc0", {2'h0, CFG_15C}, {9'h0, img['hA0][6:0], 16'h0});
		rd_reg("tc2", {2'h2, CFG_160}, {24'h0, d1[7:0]});
		rd_reg("stat", {2'h0, CFG_STAT}, 32'h03B3_3B01);
		// Read data stand for one cycle only, then fall back to zero
		@(posedge clk);
		#1 chk("rd_idle", 96'h0, 96'(rdata));
		rd_reg("none", {2'h3, CFG_070}, 32'h0000_0000);
		$display("test register port done");
		// Unheld port 0 fields and the missing port 3 ignore writes
		wr_reg({2'h0, CFG_074}, d1);
		wr_reg({2'h0, CFG_0D4}, d2);
		wr_reg({2'h3, CFG_160}, d2);
		fields();
		$display("test refused writes done");
		// A reset in mid-run restores every default and shuts config
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 set_defaults();
		fields();
		chk("not_ready", 96'(1'b0), 96'(ready));
		$display("test mid-run reset done");
		complete_run();
	end
endmodule
`default_nettype wire
